// ==== rtl/dtp_timer.sv ====
// dtp_timer: 10-bit down-counter, prescaler, pwm and underflow toggle
// assumes apb master, instruction and fast clocks given as one-cycle enable strobes, external pin sampled for edges
//
// Operation
// - counter read returns live count
// - counter write loads reload plus high bits
// - non-stop, no reload: continue from 0x3ff
// - non-stop, reload: reload value on underflow
// - single-pass counts to zero then stops
// - non-stop keeps counting after underflow
// - fast source clocks counter and pwm
// - otherwise external select picks the clock
// - external select chooses pin or instruction clock
// - edge select: falling when set, else rising
// - prescaler divides 1:2 up to 1:256
// - pwm enable drives waveform onto pins
// - polarity bit makes pwm active low
// - toggle output flips on each underflow
// - reload sets period, duty sets duty
`timescale 1ns/10ps
module dtp_timer
  import dtp_pkg::*;
(
  input  wire logic                     core_clk_i,  // 50 MHz clock
  input  wire logic                     rst_n_i,     // async reset, low
  input  wire logic                     psel_i,      // apb select
  input  wire logic                     penable_i,   // apb enable
  input  wire logic                     pwrite_i,    // apb write
  input  wire logic [dtp_pkg::ADDR_W-1:0] paddr_i,   // apb byte address
  input  wire logic [31:0]              pwdata_i,    // apb write data
  output logic      [31:0]              prdata_o,    // apb read data
  output logic                          pready_o,    // apb ready
  output logic                          pslverr_o,   // apb error
  input  wire logic                     inst_tick_i, // instruction clk
  input  wire logic                     fast_tick_i, // high osc clk
  input  wire logic                     ext_count_input_i, // ext pin
  output logic                          port_b_pin_one_o,  // pwm pin
  output logic                          port_b_pin_one_en_o,
  output logic                          port_b_pin_four_o, // pwm/toggle
  output logic                          port_b_pin_four_en_o,
  output logic [dtp_pkg::CNT_W-1:0]     countdown_value_o, // live count
  output logic                          irq_o        // interrupt level
);
  import dtp_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [7:0]       ctrl1;
    logic [7:0]       ctrl2;
    logic [7:0]       reload_low;
    logic [7:0]       duty;
    logic [7:0]       high;
    logic [7:0]       pre_cnt;
    logic             ext_prev;
    logic             stopped;
    logic             toggle;
    logic             pwm;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0]      rdata;
  } dtp_state_t;

  dtp_state_t st;
  dtp_state_t next_st;

  logic             wr_acc;
  logic             rd_acc;
  logic [7:0]       wbyte;
  logic             src_tick;
  logic             ext_edge;
  logic             pre_tap;
  logic             dec;
  logic             underflow;
  logic [CNT_W-1:0] reload_val;
  logic [CNT_W-1:0] duty_val;
  logic [2:0]       rate;
  logic             pwm_act;

  assign wr_acc = psel_i & penable_i & pwrite_i;
  assign rd_acc = psel_i & ~penable_i & ~pwrite_i;
  assign wbyte = pwdata_i[7:0];
  assign reload_val = {st.high[5:4], st.reload_low};
  assign duty_val = {st.high[1:0], st.duty};
  assign rate = st.ctrl2[C2_RATE_LSB +: 3];

  always_comb begin
    ext_edge = st.ctrl2[C2_EDGE] ? (st.ext_prev & ~ext_count_input_i)
                                 : (~st.ext_prev & ext_count_input_i);
    if (st.ctrl1[C1_FAST]) begin
      src_tick = fast_tick_i;
    end else if (st.ctrl2[C2_EXT]) begin
      src_tick = ext_edge;
    end else begin
      src_tick = inst_tick_i;
    end
    // divide by 2^(rate+1): tap the prescaler bit that wraps
    pre_tap = src_tick && ((st.pre_cnt & ((8'h02 << rate) - 8'h01))
                           == ((8'h02 << rate) - 8'h01));
    dec = st.ctrl2[C2_PRE_EN_N] ? src_tick : pre_tap;
    dec = dec & st.ctrl1[C1_RUN] & ~st.stopped;
    underflow = dec && (st.count == CNT_ZERO);
  end

  always_comb begin
    next_st = st;
    if (src_tick) begin
      next_st.pre_cnt = st.pre_cnt + 8'h01;
    end
    next_st.ext_prev = ext_count_input_i;
    if (dec) begin
      if (underflow) begin
        next_st.toggle = ~st.toggle;
        if (st.ctrl1[C1_SINGLE]) begin
          next_st.stopped = 1'b1;
        end else if (st.ctrl1[C1_RELOAD]) begin
          next_st.count = reload_val;
        end else begin
          next_st.count = CNT_MAX;
        end
      end else begin
        next_st.count = st.count - 10'h001;
      end
    end
    // pwm: active while count below duty, frame set by reload
    next_st.pwm = (st.count < duty_val);
    if (underflow) begin
      next_st.irq_stat[IRQ_UNDERFLOW] = 1'b1;
    end
    if (rd_acc) begin
      case (paddr_i)
        ADDR_COUNT:    next_st.rdata = {22'h0, st.count};
        ADDR_CTRL1:    next_st.rdata = {24'h0, st.ctrl1};
        ADDR_CTRL2:    next_st.rdata = {24'h0, st.ctrl2};
        ADDR_DUTY:     next_st.rdata = {24'h0, st.duty};
        ADDR_HIGH:     next_st.rdata = {24'h0, st.high};
        ADDR_IRQ_STAT: next_st.rdata = {31'h0, st.irq_stat};
        ADDR_IRQ_MASK: next_st.rdata = {31'h0, st.irq_mask};
        default:       next_st.rdata = RD_ZERO;
      endcase
    end
    if (wr_acc) begin
      case (paddr_i)
        ADDR_COUNT: begin
          next_st.reload_low = wbyte;
          next_st.count = {st.high[5:4], wbyte};
          next_st.stopped = 1'b0;
          next_st.pre_cnt = 8'h00;
        end
        ADDR_CTRL1: next_st.ctrl1 = wbyte & C1_MASK;
        ADDR_CTRL2: begin
          next_st.ctrl2 = wbyte & C2_MASK;
          next_st.pre_cnt = 8'h00;
        end
        ADDR_DUTY: next_st.duty = wbyte;
        ADDR_HIGH: next_st.high = wbyte & HIGH_MASK;
        ADDR_IRQ_STAT: begin
          // set wins over clear
          next_st.irq_stat = (st.irq_stat & ~pwdata_i[IRQ_W-1:0])
                             | (underflow ? 1'b1 : 1'b0);
        end
        ADDR_IRQ_MASK: next_st.irq_mask = pwdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.ctrl1 <= C1_RESET;
      st.ctrl2 <= C2_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign pwm_act = st.pwm ^ st.ctrl1[C1_POL];
  assign prdata_o = st.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign countdown_value_o = st.count;
  assign irq_o = |(st.irq_stat & st.irq_mask);
  // output enables are low while driving
  assign port_b_pin_one_o = pwm_act;
  assign port_b_pin_one_en_o = ~st.ctrl1[C1_PWM_EN];
  assign port_b_pin_four_o = st.ctrl1[C1_TOGGLE_EN] ? st.toggle
                                                    : pwm_act;
  assign port_b_pin_four_en_o = ~(st.ctrl1[C1_TOGGLE_EN]
                                  | st.ctrl1[C1_PWM_EN]);
endmodule : dtp_timer

// ==== rtl/dtp_pkg.sv ====
// dtp_pkg: constants for the down-counting timer with prescaler and pwm
// assumes apb byte addressing, 32-bit data, registers on word boundaries
package dtp_pkg;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned ADDR_W = 8;
  // printed offsets are indices; byte address is index times four
  localparam logic [ADDR_W-1:0] IDX_COUNT = 8'h00;
  localparam logic [ADDR_W-1:0] IDX_CTRL1 = 8'h01;
  localparam logic [ADDR_W-1:0] IDX_CTRL2 = 8'h02;
  localparam logic [ADDR_W-1:0] IDX_DUTY = 8'h03;
  localparam logic [ADDR_W-1:0] IDX_HIGH = 8'h04;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 8'h05;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CTRL2 = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_DUTY = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_HIGH = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h18;
  // control one fields
  localparam int unsigned C1_RUN = 0;
  localparam int unsigned C1_RELOAD = 1;
  localparam int unsigned C1_SINGLE = 2;
  localparam int unsigned C1_FAST = 3;
  localparam int unsigned C1_TOGGLE_EN = 5;
  localparam int unsigned C1_POL = 6;
  localparam int unsigned C1_PWM_EN = 7;
  localparam logic [7:0] C1_RESET = 8'h00;
  localparam logic [7:0] C1_MASK = 8'hef;
  // control two fields
  localparam int unsigned C2_RATE_LSB = 0;
  localparam int unsigned C2_PRE_EN_N = 3;
  localparam int unsigned C2_EDGE = 4;
  localparam int unsigned C2_EXT = 5;
  localparam logic [7:0] C2_RESET = 8'h3f;
  localparam logic [7:0] C2_MASK = 8'h3f;
  // high-bits register: [5:4] reload msbs, [1:0] duty msbs
  localparam logic [7:0] HIGH_MASK = 8'h33;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  // interrupt status bits
  localparam int unsigned IRQ_UNDERFLOW = 0;
  localparam int unsigned IRQ_W = 1;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : dtp_pkg

// ==== tb/dtp_timer_assertions.sv ====
// checker: port-level properties of the timer block
// assumes binding onto dtp_timer, one clock domain
`timescale 1ns/10ps
module dtp_chk
  import dtp_pkg::*;
(
  input wire logic                      core_clk_i,
  input wire logic                      rst_n_i,
  input wire logic                      psel_i,
  input wire logic                      penable_i,
  input wire logic                      pwrite_i,
  input wire logic [dtp_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0]               pwdata_i,
  input wire logic [31:0]               prdata_o,
  input wire logic                      pready_o,
  input wire logic                      inst_tick_i,
  input wire logic                      fast_tick_i,
  input wire logic                      ext_count_input_i,
  input wire logic                      port_b_pin_one_en_o,
  input wire logic                      port_b_pin_four_en_o,
  input wire logic [dtp_pkg::CNT_W-1:0] countdown_value_o,
  input wire logic                      irq_o
);
  import dtp_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wr(a);
    psel_i && penable_i && pwrite_i && paddr_i == a;
  endsequence
  sequence s_rd(a);
    psel_i && !penable_i && !pwrite_i && paddr_i == a;
  endsequence
  a_apb_ready: assert property (psel_i && penable_i |-> pready_o)
    else $error("no ready");
  a_read_live: assert property (s_rd(ADDR_COUNT) |=>
    prdata_o == {22'h0, $past(countdown_value_o)}) else $error("read");
  a_count_load: assert property (s_wr(ADDR_COUNT) |=>
    countdown_value_o[7:0] == $past(pwdata_i[7:0])) else $error("load");
  a_count_step: assert property ($changed(countdown_value_o) |->
    countdown_value_o == $past(countdown_value_o) - 10'h1
    || $past(countdown_value_o) == CNT_ZERO
    || $past(psel_i && pwrite_i && paddr_i == ADDR_COUNT))
    else $error("step");
  a_count_hold: assert property (!inst_tick_i && !fast_tick_i
    && ext_count_input_i == $past(ext_count_input_i, 2)
    && ext_count_input_i == $past(ext_count_input_i) && !psel_i
    |=> $stable(countdown_value_o)) else $error("hold");
  a_pins_off: assert property (s_wr(ADDR_CTRL1)
    ##0 pwdata_i[7:5] == 3'h0
    |=> port_b_pin_one_en_o && port_b_pin_four_en_o) else $error("off");
  a_pwm_on: assert property (s_wr(ADDR_CTRL1) ##0 pwdata_i[C1_PWM_EN]
    |=> !port_b_pin_one_en_o && !port_b_pin_four_en_o) else $error("on");
  a_irq_cause: assert property ($rose(irq_o) |->
    $past(countdown_value_o) == CNT_ZERO || $past(psel_i && pwrite_i))
    else $error("irq");
endmodule : dtp_chk
bind dtp_timer dtp_chk dtp_chk_i (.core_clk_i, .rst_n_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .inst_tick_i,
  .fast_tick_i, .ext_count_input_i, .port_b_pin_one_en_o,
  .port_b_pin_four_en_o, .countdown_value_o, .irq_o);

// ==== tb/testbench.sv ====
// testbench: register-level checks of the timer block
// assumes zero-wait apb and tick strobes driven from here
`timescale 1ns/10ps
module testbench;
  import dtp_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
  logic inst = 0, fast = 0, ext = 0, rdy, p1, p1en, p4, p4en, irq, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] wd = 32'h0, rdata, q[$];
  logic [9:0] cnt;
  logic [15:0] lf = 16'd3353;
  int failures = 0, cmp_count = 0;
  dtp_timer dtp_timer_i (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(wd),
    .prdata_o(rdata), .pready_o(rdy), .pslverr_o(err), .inst_tick_i(inst),
    .fast_tick_i(fast), .ext_count_input_i(ext), .port_b_pin_one_o(p1),
    .port_b_pin_one_en_o(p1en), .port_b_pin_four_o(p4),
    .port_b_pin_four_en_o(p4en), .countdown_value_o(cnt), .irq_o(irq));
  initial forever #10 clk = ~clk;
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("Error %0t exp %h got %h", $time, e, g);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      conclude();
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic run(input logic [7:0] c, input logic [9:0] s, input int n,
                     input logic f, input logic [9:0] e);
    apb(1'b1, ADDR_COUNT, {24'h0, s[7:0]});
    apb(1'b1, ADDR_CTRL1, {24'h0, c});
    repeat (n) begin
      if (f) fast <= 1'b1;
      else inst <= 1'b1;
      @(posedge clk);
      fast <= 1'b0;
      inst <= 1'b0;
      @(posedge clk);
    end
    cmp({22'h0, e}, {22'h0, cnt});
    rd(ADDR_COUNT, {22'h0, e});
    apb(1'b1, ADDR_CTRL1, 32'h0);
  endtask : run
  always @(posedge clk)
    if (psel && pen && !pwr && rdy === 1'b1 && q.size() > 0) begin
      cmp(q.pop_front(), rdata);
      cmp(32'h0, {31'h0, err});
    end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_CTRL2, {24'h0, C2_RESET});
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    apb(1'b1, 8'h1c, {16'h0, lf});
    rd(8'h1c, 32'h0);
    apb(1'b1, ADDR_HIGH, 32'h30);
    apb(1'b1, ADDR_COUNT, {24'h0, lf[7:0]});
    rd(ADDR_COUNT, {22'h0, 2'b11, lf[7:0]});
    apb(1'b1, ADDR_HIGH, 32'h0);
    apb(1'b1, ADDR_CTRL2, 32'h08);
    run(8'h01, 10'h2, 3, 1'b0, 10'h3ff);
    run(8'h03, 10'h3, 4, 1'b0, 10'h003);
    run(8'h05, 10'h1, 3, 1'b0, 10'h000);
    run(8'h00, 10'h7, 3, 1'b0, 10'h007);
    run(8'h09, 10'h7, 3, 1'b1, 10'h004);
    run(8'h09, 10'h7, 3, 1'b0, 10'h007);
    $display("count modes done");
    rd(ADDR_IRQ_STAT, 32'h1);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    cmp(32'h1, {31'h0, irq});
    apb(1'b1, ADDR_IRQ_STAT, 32'h1);
    cmp(32'h0, {31'h0, irq});
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, ADDR_CTRL2, 32'h08 | 32'(r));
      apb(1'b1, ADDR_CTRL2, 32'(r));
      run(8'h01, 10'h10, (2 << r) - 1, 1'b0, 10'h010);
      run(8'h01, 10'h10, 2 << r, 1'b0, 10'h00f);
    end
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, ADDR_CTRL2, 32'h28 | 32'(e << 4));
      run(8'h01, 10'h20, 0, 1'b0, 10'h020);
      apb(1'b1, ADDR_CTRL1, 32'h01);
      ext <= 1'b1;
      repeat (3) @(posedge clk);
      rd(ADDR_COUNT, e ? 32'h20 : 32'h1f);
      ext <= 1'b0;
      repeat (3) @(posedge clk);
      rd(ADDR_COUNT, 32'h1f);
    end
    $display("sources done");
    apb(1'b1, ADDR_CTRL1, 32'hc0);
    cmp(32'h1, {30'h0, p1en, p1});
    apb(1'b1, ADDR_CTRL1, 32'h20);
    cmp(32'h3, {30'h0, p1en, p4});
    cmp(32'h0, {31'h0, p4en});
    apb(1'b1, ADDR_CTRL1, 32'h80);
    apb(1'b1, ADDR_DUTY, 32'h20);
    @(negedge clk);
    cmp(32'h1, {29'h0, p1en, p4en, p4});
    cmp(32'h1, {31'h0, p1});
    @(posedge clk);
    $display("pins done");
    conclude();
  end
endmodule : testbench
